// ==== vdca_map.svh ====
`ifndef VDCA_MAP_SVH
`define VDCA_MAP_SVH
// Contract
// - Code 38 carries command bits and mask.
// - Code 39 sets manual position, applied immediately.
// - Code 40 reports position, event below 5%.
// - Code 41 status word, 42 alarms, on change.
// - All status messages also sent every 5 s.
// - Serial port defaults 9600, even, one stop.
// - Serial variable addresses count from one.
// - Enable refresh supervised on either link path.
// - Warning at half delay, lost at full.
// - Alarm bits 3:2 encode communication state.
// - Alarms self-clear except parameters alarm and memory alarm held after interrupted conversion.
// - Any alarm drives LED and configured relay.
// - Alarm word bit assignment fixed.
// - Storage fault: memory alarm, defaults, no store.
// - Interrupted conversion: memory and parameter alarms.
// - Standby-off check sets bit 1, code.
// - Code 0 ok, 1 bad enable mode.
// - Codes 2-5 invalid probe types.
// - Codes 6-9 duplicated usage, algorithm only.
// - Codes 10-13 type versus usage mismatch.
// - Codes 14-17 wait input, 18 all.
// - Codes 19-20 scaling limits, 21 no primary.
// - Codes 22-24 valve copy, valve, probe.

// ----------
// message codes and link addressing
// ----------
`define CODE_CMD 8'h26
`define CODE_MANUAL 8'h27
`define CODE_POS 8'h28
`define CODE_STAT 8'h29
`define CODE_ALARM 8'h2A
`define MB_BASE 8'h01
`define POS_LOW_PCT 7'h05
// ----------
// command and alarm bit positions
// ----------
`define CB_ENA 0
`define CB_RESYNC 1
`define CB_MODE 2
`define CB_SET 3
`define AL_MEM 0
`define AL_CFG 1
`define AL_COM 2
`define AL_PROBE 4
`define AL_POWER 8
`define AL_BATT 9
`define AL_ALG 10
`define AL_PARAM 12
// ----------
// timing
// ----------
`define CLK_HZ 100000000
`define TICK_MS 1
`define TICK_CYCLES (`CLK_HZ / 1000 * `TICK_MS)
`define PERIOD_S 5
`define PERIOD_TICKS (`PERIOD_S * 1000 / `TICK_MS)
// ----------
// serial port defaults: baud[19:3] parity[2:1] stop[0]
// ----------
`define MB_BAUD_DEF 17'h02580
`define MB_PARITY_EVEN 2'h2
`define MB_STOP_ONE 1'b0
`define MB_CFG_RESET {`MB_BAUD_DEF, `MB_PARITY_EVEN, `MB_STOP_ONE}
// ----------
// configuration values and check codes
// ----------
`define FSM_STANDBY_OFF 8'h00
`define MODE_LOCAL_DI 4'h0
`define MODE_LOCAL_HV 4'h1
`define MODE_COMM_MIN 4'h2
`define MODE_ALONE_MIN 4'h6
`define MODE_MAX 4'h9
`define FUNC_ENABLE 4'h1
`define CTRL_ALGO_MIN 4'h6
`define PT_NTC 4'h1
`define PT_PT1000 4'h2
`define PT_CUR 4'h3
`define PT_VOLT 4'h4
`define PT_SCALE 4'h5
`define US_TEMP_PRI 4'h1
`define US_PRESS_PRI 4'h2
`define US_TEMP_BAK 4'h3
`define US_PRESS_BAK 4'h4
`define CW_OK 5'h00
`define CW_MODE 5'h01
`define CW_TYPE 5'h02
`define CW_DUP 5'h06
`define CW_MISMATCH 5'h0A
`define CW_WAIT 5'h0E
`define CW_WAIT_ALL 5'h12
`define CW_XLIM 5'h13
`define CW_YLIM 5'h14
`define CW_NO_PRIMARY 5'h15
`define CW_COPY 5'h16
`define CW_VALVE 5'h17
`define CW_PROBE 5'h18
// ----------
// controller register offsets
// ----------
`define RA_CMD 8'h00
`define RA_MANUAL 8'h04
`define RA_POS 8'h08
`define RA_STAT 8'h0C
`define RA_ALARM 8'h10
`define RA_LINK 8'h14
`endif

// ==== vdca_pkg.sv ====
package vdca_pkg;
    // device state, registered as one word
    typedef struct packed {
        logic [3:0] cmd;
        logic [15:0] manual;
        logic manual_stb;
        logic [15:0] refresh_cnt;
        logic [15:0] period_cnt;
        logic [2:0] pend;
        logic prev_low;
        logic [15:0] prev_stat;
        logic mem_hold;
        logic param_alarm;
        logic [4:0] cfg_code;
        logic [15:0] alarm;
        logic led;
        logic relay;
        logic [19:0] mb_cfg;
        logic tx_valid;
        logic [7:0] tx_code;
        logic [15:0] tx_data;
    } vdca_dev_st_t;

    // controller state, registered as one word
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic via_mb;
        logic [15:0] refresh_ms;
        logic [15:0] refresh_cnt;
        logic [15:0] last_cmd;
        logic [15:0] pos;
        logic [15:0] stat;
        logic [15:0] alarm;
        logic tx_valid;
        logic [7:0] tx_addr;
        logic [15:0] tx_data;
    } vdca_ctl_st_t;

    typedef struct packed {
        logic [19:0] cnt;
        logic tick;
    } vdca_tick_st_t;
endpackage

// ==== vdca_if.sv ====
interface vdca_if;
    logic c2d_valid;
    logic c2d_via_mb;
    logic [7:0] c2d_addr;
    logic [15:0] c2d_data;
    logic d2c_valid;
    logic [7:0] d2c_code;
    logic [15:0] d2c_data;

    modport dev (
        input c2d_valid, c2d_via_mb, c2d_addr, c2d_data,
        output d2c_valid, d2c_code, d2c_data
    );
    modport ctl (
        output c2d_valid, c2d_via_mb, c2d_addr, c2d_data,
        input d2c_valid, d2c_code, d2c_data
    );
endinterface

// ==== vdca_tick.sv ====
`include "vdca_map.svh"
// ----------
// one-cycle enable pulse every CYCLES clocks
// ----------
module vdca_tick #(
    parameter logic [19:0] CYCLES = 20'(`TICK_CYCLES)
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    import vdca_pkg::*;
    vdca_tick_st_t s, n;

    // wrap at CYCLES-1 so the period is exact
    always_comb begin
        n = s;
        n.tick = (s.cnt == CYCLES - 20'h00001);
        n.cnt = n.tick ? 20'h00000 : s.cnt + 20'h00001;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tick = s.tick;
endmodule // vdca_tick

// ==== vdca_device.sv ====
`include "vdca_map.svh"
// ----------
// valve driver end: commands, status, alarms
// ----------
module vdca_device #(
    parameter logic [19:0] TICK_CYCLES = 20'(`TICK_CYCLES),
    parameter logic [15:0] PERIOD_TICKS = 16'(`PERIOD_TICKS)
) (
    input wire logic pclk,
    input wire logic presetn,
    vdca_if.dev lnk,
    input wire logic [7:0] fsm_status,
    input wire logic [6:0] valve_pos_pct,
    input wire logic [3:0] link_enabling_mode,
    input wire logic link_alarm_enable,
    input wire logic [15:0] link_loss_delay,
    input wire logic [3:0] main_control_type,
    input wire logic [3:0] input_one_function,
    input wire logic [3:0] hv_input_function,
    input wire logic [15:0] input_probe_types,
    input wire logic [15:0] input_usages,
    input wire logic [3:0] input_cfg_pending,
    input wire logic scale_xlim_err,
    input wire logic scale_ylim_err,
    input wire logic valve_copy_err,
    input wire logic valve_param_err,
    input wire logic probe_cfg_err,
    input wire logic mem_access_fail,
    input wire logic conversion_halted,
    input wire logic defaults_reloaded,
    input wire logic param_recover,
    input wire logic [3:0] probe_faults,
    input wire logic power_failure_fault,
    input wire logic battery_fault,
    input wire logic algorithm_fault,
    input wire logic relay_on_alarm,
    input wire logic mb_cfg_write,
    input wire logic [19:0] mb_cfg_value,
    output logic valve_enable_command,
    output logic resync_request,
    output logic functioning_mode_select,
    output logic superheat_set_select,
    output logic [15:0] manual_position_setpoint,
    output logic manual_position_strobe,
    output logic [15:0] alarm_word,
    output logic [4:0] config_warning_code,
    output logic alarm_led,
    output logic alarm_relay,
    output logic use_default_params,
    output logic store_inhibit,
    output logic [19:0] mb_port_cfg
);
    import vdca_pkg::*;
    vdca_dev_st_t s, n;
    logic tick;

    vdca_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    // ----------
    // configuration check, first failing code wins
    // ----------
    logic [4:0] cfg_now;
    logic [3:0] ty, us, uj;
    logic algo, has_tp, has_pp, done;
    always_comb begin
        cfg_now = `CW_OK;
        ty = 4'h0;
        us = 4'h0;
        uj = 4'h0;
        done = 1'b0;
        has_tp = 1'b0;
        has_pp = 1'b0;
        algo = (main_control_type >= `CTRL_ALGO_MIN);
        if (link_enabling_mode > `MODE_MAX
            || (link_enabling_mode == `MODE_LOCAL_DI
                && input_one_function != `FUNC_ENABLE)
            || (link_enabling_mode == `MODE_LOCAL_HV
                && hv_input_function != `FUNC_ENABLE)) begin
            cfg_now = `CW_MODE;
            done = 1'b1;
        end
        for (int i = 0; i < 4; i++) begin
            ty = input_probe_types[i*4 +: 4];
            if (!done && (ty == 4'h0 || ty > `PT_SCALE)) begin
                cfg_now = `CW_TYPE + 5'(i);
                done = 1'b1;
            end
        end
        for (int i = 0; i < 4; i++) begin
            us = input_usages[i*4 +: 4];
            for (int j = 0; j < 4; j++) begin
                uj = input_usages[j*4 +: 4];
                // distinct or null, only with algorithm control
                if (!done && algo && i != j && us != 4'h0 && us == uj) begin
                    cfg_now = `CW_DUP + 5'(i);
                    done = 1'b1;
                end
            end
        end
        for (int i = 0; i < 4; i++) begin
            ty = input_probe_types[i*4 +: 4];
            us = input_usages[i*4 +: 4];
            has_tp = has_tp | (us == `US_TEMP_PRI);
            has_pp = has_pp | (us == `US_PRESS_PRI);
            if (!done && algo
                && (((us == `US_TEMP_PRI || us == `US_TEMP_BAK)
                     && !(ty == `PT_NTC || ty == `PT_PT1000
                          || ty == `PT_SCALE))
                    || ((us == `US_PRESS_PRI || us == `US_PRESS_BAK)
                     && !(ty == `PT_CUR || ty == `PT_VOLT
                          || ty == `PT_SCALE)))) begin
                cfg_now = `CW_MISMATCH + 5'(i);
                done = 1'b1;
            end
        end
        if (!done && input_cfg_pending == 4'hF) begin
            cfg_now = `CW_WAIT_ALL;
            done = 1'b1;
        end
        for (int i = 0; i < 4; i++) begin
            if (!done && input_cfg_pending[i]) begin
                cfg_now = `CW_WAIT + 5'(i);
                done = 1'b1;
            end
        end
        if (done) begin
            cfg_now = cfg_now;
        end else if (scale_xlim_err) begin
            cfg_now = `CW_XLIM;
        end else if (scale_ylim_err) begin
            cfg_now = `CW_YLIM;
        end else if (algo && !(has_tp && has_pp)) begin
            cfg_now = `CW_NO_PRIMARY;
        end else if (valve_copy_err) begin
            cfg_now = `CW_COPY;
        end else if (valve_param_err) begin
            cfg_now = `CW_VALVE;
        end else if (probe_cfg_err) begin
            cfg_now = `CW_PROBE;
        end
    end

    // ----------
    // next state: commands, supervision, alarms, messages
    // ----------
    logic [7:0] rx_code;
    logic [3:0] msk;
    logic [1:0] com;
    logic [15:0] stat_now;
    logic low_now, period_hit, supervise;
    logic [2:0] trig;
    always_comb begin
        n = s;
        n.manual_stb = 1'b0;
        n.tx_valid = 1'b0;
        msk = lnk.c2d_data[11:8];
        // serial addresses are one-based, codes zero-based
        rx_code = lnk.c2d_via_mb ? lnk.c2d_addr - `MB_BASE
                                 : lnk.c2d_addr;
        if (lnk.c2d_valid && rx_code == `CODE_CMD) begin
            n.cmd = (s.cmd & ~msk) | (lnk.c2d_data[3:0] & msk);
        end
        if (lnk.c2d_valid && rx_code == `CODE_MANUAL) begin
            n.manual = lnk.c2d_data;
            n.manual_stb = 1'b1;
        end
        // a refresh counts whichever path carried it
        if (lnk.c2d_valid && rx_code == `CODE_CMD && msk[`CB_ENA]) begin
            n.refresh_cnt = 16'h0000;
        end else if (tick && s.refresh_cnt != 16'hFFFF) begin
            n.refresh_cnt = s.refresh_cnt + 16'h0001;
        end
        supervise = link_alarm_enable
                    && link_enabling_mode >= `MODE_COMM_MIN;
        com = 2'b00;
        if (supervise && s.refresh_cnt > link_loss_delay) begin
            com = (link_enabling_mode >= `MODE_ALONE_MIN)
                  ? 2'b10 : 2'b11;
        end else if (supervise
                     && s.refresh_cnt > {1'b0, link_loss_delay[15:1]}) begin
            com = 2'b01;
        end
        // sticky sources: set wins over clear
        n.mem_hold = conversion_halted
                     | (s.mem_hold & ~defaults_reloaded);
        n.param_alarm = conversion_halted
                        | (s.param_alarm & ~param_recover);
        if (fsm_status == `FSM_STANDBY_OFF) begin
            n.cfg_code = cfg_now;
        end
        n.alarm = 16'h0000;
        n.alarm[`AL_MEM] = mem_access_fail | s.mem_hold;
        n.alarm[`AL_CFG] = (s.cfg_code != `CW_OK);
        n.alarm[`AL_COM +: 2] = com;
        n.alarm[`AL_PROBE +: 4] = probe_faults;
        n.alarm[`AL_POWER] = power_failure_fault;
        n.alarm[`AL_BATT] = battery_fault;
        n.alarm[`AL_ALG] = algorithm_fault;
        n.alarm[`AL_PARAM] = s.param_alarm;
        n.led = |s.alarm;
        n.relay = relay_on_alarm & (|s.alarm);
        if (mb_cfg_write) begin
            n.mb_cfg = mb_cfg_value;
        end
        // periodic report
        period_hit = tick && (s.period_cnt >= PERIOD_TICKS - 16'h0001);
        if (period_hit) begin
            n.period_cnt = 16'h0000;
        end else if (tick) begin
            n.period_cnt = s.period_cnt + 16'h0001;
        end
        stat_now = {5'h00, s.cmd[`CB_SET], s.cmd[`CB_RESYNC],
                    s.cmd[`CB_ENA], fsm_status};
        low_now = (valve_pos_pct < `POS_LOW_PCT);
        n.prev_low = low_now;
        n.prev_stat = stat_now;
        trig[0] = period_hit | (low_now & ~s.prev_low);
        trig[1] = period_hit | (stat_now != s.prev_stat);
        trig[2] = period_hit | (n.alarm != s.alarm);
        // one message a cycle, alarms first; new events never lost
        n.pend = s.pend;
        if (s.pend[2]) begin
            n.tx_valid = 1'b1;
            n.tx_code = `CODE_ALARM;
            n.tx_data = s.alarm;
            n.pend[2] = 1'b0;
        end else if (s.pend[1]) begin
            n.tx_valid = 1'b1;
            n.tx_code = `CODE_STAT;
            n.tx_data = stat_now;
            n.pend[1] = 1'b0;
        end else if (s.pend[0]) begin
            n.tx_valid = 1'b1;
            n.tx_code = `CODE_POS;
            n.tx_data = {9'h000, valve_pos_pct};
            n.pend[0] = 1'b0;
        end
        n.pend = n.pend | trig;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.mb_cfg <= `MB_CFG_RESET;
            s.prev_low <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // ----------
    // outputs, all straight from the state register
    // ----------
    assign valve_enable_command = s.cmd[`CB_ENA];
    assign resync_request = s.cmd[`CB_RESYNC];
    assign functioning_mode_select = s.cmd[`CB_MODE];
    assign superheat_set_select = s.cmd[`CB_SET];
    assign manual_position_setpoint = s.manual;
    assign manual_position_strobe = s.manual_stb;
    assign alarm_word = s.alarm;
    assign config_warning_code = s.cfg_code;
    assign alarm_led = s.led;
    assign alarm_relay = s.relay;
    // defaults stay in use while storage is unreachable
    assign use_default_params = s.alarm[`AL_MEM];
    assign store_inhibit = s.alarm[`AL_MEM];
    assign mb_port_cfg = s.mb_cfg;
    assign lnk.d2c_valid = s.tx_valid;
    assign lnk.d2c_code = s.tx_code;
    assign lnk.d2c_data = s.tx_data;
endmodule // vdca_device

// ==== vdca_ctrl.sv ====
`include "vdca_map.svh"
// ----------
// supervisory controller end, apb slave to software
// ----------
module vdca_ctrl #(
    parameter logic [19:0] TICK_CYCLES = 20'(`TICK_CYCLES)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    vdca_if.ctl lnk
);
    import vdca_pkg::*;
    vdca_ctl_st_t s, n;
    logic tick;

    vdca_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    // serial path addresses are one-based
    function automatic logic [7:0] link_addr(input logic mb,
                                             input logic [7:0] code);
        link_addr = mb ? code + `MB_BASE : code;
    endfunction

    // one wait state: answer registered, write lands with pready
    logic acc, hit;
    always_comb begin
        n = s;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        n.tx_valid = 1'b0;
        acc = psel & penable;
        hit = (paddr == `RA_CMD) || (paddr == `RA_MANUAL)
              || (paddr == `RA_POS) || (paddr == `RA_STAT)
              || (paddr == `RA_ALARM) || (paddr == `RA_LINK);
        if (acc && !s.pready) begin
            n.pready = 1'b1;
            n.pslverr = ~hit;
            case (paddr)
                `RA_CMD: n.prdata = {16'h0000, s.last_cmd};
                `RA_POS: n.prdata = {16'h0000, s.pos};
                `RA_STAT: n.prdata = {16'h0000, s.stat};
                `RA_ALARM: n.prdata = {16'h0000, s.alarm};
                `RA_LINK: n.prdata = {s.refresh_ms, 15'h0000, s.via_mb};
                default: n.prdata = 32'h00000000;
            endcase
        end
        if (tick && s.refresh_cnt != 16'hFFFF) begin
            n.refresh_cnt = s.refresh_cnt + 16'h0001;
        end
        if (acc && s.pready && pwrite && paddr == `RA_CMD) begin
            n.last_cmd = pwdata[15:0];
            n.tx_valid = 1'b1;
            n.tx_addr = link_addr(s.via_mb, `CODE_CMD);
            n.tx_data = pwdata[15:0];
            n.refresh_cnt = 16'h0000;
        end else if (acc && s.pready && pwrite && paddr == `RA_MANUAL) begin
            n.tx_valid = 1'b1;
            n.tx_addr = link_addr(s.via_mb, `CODE_MANUAL);
            n.tx_data = pwdata[15:0];
        end else if (s.refresh_ms != 16'h0000
                     && s.refresh_cnt >= s.refresh_ms) begin
            // keep the enable alive on either path
            n.tx_valid = 1'b1;
            n.tx_addr = link_addr(s.via_mb, `CODE_CMD);
            n.tx_data = s.last_cmd;
            n.refresh_cnt = 16'h0000;
        end
        if (acc && s.pready && pwrite && paddr == `RA_LINK) begin
            n.via_mb = pwdata[0];
            n.refresh_ms = pwdata[31:16];
        end
        if (lnk.d2c_valid) begin
            case (lnk.d2c_code)
                `CODE_POS: n.pos = lnk.d2c_data;
                `CODE_STAT: n.stat = lnk.d2c_data;
                `CODE_ALARM: n.alarm = lnk.d2c_data;
                default: n.pos = s.pos;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign lnk.c2d_valid = s.tx_valid;
    assign lnk.c2d_via_mb = s.via_mb;
    assign lnk.c2d_addr = s.tx_addr;
    assign lnk.c2d_data = s.tx_data;
endmodule // vdca_ctrl

// ==== vdca_checker.sv ====
// interface watcher; period limit assumes 8 ticks of 10 cycles
module vdca_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic c2d_valid,
    input wire logic c2d_via_mb,
    input wire logic [7:0] c2d_addr,
    input wire logic [15:0] c2d_data,
    input wire logic d2c_valid,
    input wire logic [7:0] d2c_code,
    input wire logic [15:0] d2c_data
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIM = 100;
    int cnt_reg;
    logic pos_sent;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign pos_sent = d2c_valid && d2c_code == 8'h28;
    // cycles since the last position message
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cnt_reg <= 0;
        else if (pos_sent) cnt_reg <= 0;
        else cnt_reg <= cnt_reg + 1;
    end
    a_can_code: assert property (c2d_valid && !c2d_via_mb |->
        c2d_addr inside {8'h26, 8'h27}) else $error("bad link code");
    a_mb_code: assert property (c2d_valid && c2d_via_mb |->
        c2d_addr inside {8'h27, 8'h28}) else $error("bad serial addr");
    a_dev_code: assert property (d2c_valid |->
        d2c_code inside {8'h28, 8'h29, 8'h2A}) else $error("bad code");
    a_pos_width: assert property (pos_sent |->
        d2c_data[15:7] == '0) else $error("position out of range");
    a_stat_spare: assert property (d2c_valid && d2c_code == 8'h29
        |-> d2c_data[15:11] == '0) else $error("status spare bits");
    a_alarm_spare: assert property (d2c_valid && d2c_code == 8'h2A
        |-> !d2c_data[11] && d2c_data[15:13] == '0)
        else $error("alarm spare bits");
    a_period_send: assert property (cnt_reg <= LIM)
        else $error("periodic position missing");
    a_pos_single: assert property (pos_sent |=> !pos_sent)
        else $error("position sent twice");
endmodule // vdca_checker

// ==== vdca_tb.sv ====
`include "vdca_map.svh"
`define CK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
    $display("[ERR] %0t %h %h", $time, a, b); end end
`define PULSE(s) begin s <= 1'b1; @(posedge pclk); s <= 1'b0; wt(3); end
module vdca_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic [7:0] paddr = '0, fsm_status = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, link_alarm_enable = 0, scale_xlim_err = 0;
    int err_total = 0, checked = 0;
    logic [6:0] valve_pos_pct = 7'h32;
    logic [3:0] link_enabling_mode = '0, main_control_type = 4'h6;
    logic [3:0] input_one_function = 4'h1, hv_input_function = 4'h1;
    logic [3:0] input_cfg_pending = '0, probe_faults = '0;
    logic [15:0] link_loss_delay = 16'h0006, manual_position_setpoint;
    logic [15:0] input_probe_types = 16'h1131, input_usages = 16'h0021;
    logic scale_ylim_err = 0, valve_copy_err = 0, valve_param_err = 0;
    logic probe_cfg_err = 0, mem_access_fail = 0, conversion_halted = 0;
    logic defaults_reloaded = 0, param_recover = 0, battery_fault = 0;
    logic power_failure_fault = 0, algorithm_fault = 0, mb_cfg_write = 0;
    logic relay_on_alarm = 0, valve_enable_command, resync_request;
    logic [19:0] mb_cfg_value = 20'h12345, mb_port_cfg;
    logic functioning_mode_select, superheat_set_select, alarm_led;
    logic manual_position_strobe, alarm_relay, use_default_params;
    logic store_inhibit;
    logic [15:0] alarm_word;
    logic [4:0] config_warning_code;
    vdca_if bus();
    vdca_ctrl #(.TICK_CYCLES(20'h0000A)) u_vdca_ctrl (.*, .lnk(bus.ctl));
    vdca_device #(.TICK_CYCLES(20'h0000A), .PERIOD_TICKS(16'h0008))
        u_vdca_device (.*, .lnk(bus.dev));
    vdca_checker u_vdca_checker (.pclk, .presetn,
        .c2d_valid(bus.c2d_valid), .c2d_via_mb(bus.c2d_via_mb),
        .c2d_addr(bus.c2d_addr), .c2d_data(bus.c2d_data),
        .d2c_valid(bus.d2c_valid), .d2c_code(bus.d2c_code),
        .d2c_data(bus.d2c_data));
    // ----------
    // bus tasks
    // ----------
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // leading edge parts setup from the last release
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic t_misc;
        `CK(mb_port_cfg, `MB_CFG_RESET)
        `PULSE(mb_cfg_write)
        `CK(mb_port_cfg, 20'h12345)
        apb(1'b0, 8'h40, '0);
        `CK(e, 1'b1)
    endtask
    task automatic t_cmd;
        apb(1'b1, `RA_CMD, 32'h00000F05);
        wt(3);
        `CK({superheat_set_select, functioning_mode_select, resync_request,
            valve_enable_command}, 4'h5)
        apb(1'b1, `RA_CMD, 32'h0000010E);
        wt(3);
        `CK({superheat_set_select, functioning_mode_select, resync_request,
            valve_enable_command}, 4'h4)
        apb(1'b1, `RA_MANUAL, 32'h00001234);
        repeat (2) @(negedge pclk);
        `CK(manual_position_strobe, 1'b1)
        `CK(manual_position_setpoint, 16'h1234)
    endtask
    task automatic t_stat;
        apb(1'b1, `RA_CMD, 32'h00000F08);
        fsm_status <= 8'h5A;
        valve_pos_pct <= 7'h03;
        wt(8);
        apb(1'b0, `RA_STAT, '0);
        `CK(q, 32'h0000045A)
        apb(1'b0, `RA_POS, '0);
        `CK(q, 32'h00000003)
        fsm_status <= '0;
        valve_pos_pct <= 7'h32;
    endtask
    task automatic t_alarm;
        {probe_faults, power_failure_fault, battery_fault, algorithm_fault,
            relay_on_alarm} <= 8'h5F;
        wt(8);
        `CK(alarm_word, 16'h0750)
        `CK({alarm_led, alarm_relay}, 2'h3)
        apb(1'b0, `RA_ALARM, '0);
        `CK(q, 32'h00000750)
        {probe_faults, power_failure_fault, battery_fault,
            algorithm_fault} <= '0;
        `PULSE(mem_access_fail)
        `CK(alarm_word, 16'h0000)
        mem_access_fail <= 1'b1;
        wt(3);
        `CK({alarm_word[0], use_default_params, store_inhibit}, 3'h7)
        mem_access_fail <= 1'b0;
        `PULSE(conversion_halted)
        `CK(alarm_word, 16'h1001)
        `PULSE(defaults_reloaded)
        `CK(alarm_word, 16'h1000)
        `PULSE(param_recover)
        `CK({alarm_word, alarm_led}, 17'h00000)
    endtask
    localparam logic [15:0] TY = 16'h1131, US = 16'h0021;
    task automatic cfg(input logic [3:0] m, input logic [15:0] t, u,
                       input logic [3:0] p, input logic [4:0] f, x);
        link_enabling_mode <= m;
        input_probe_types <= t;
        input_usages <= u;
        input_cfg_pending <= p;
        {scale_xlim_err, scale_ylim_err, valve_copy_err, valve_param_err,
            probe_cfg_err} <= f;
        wt(4);
        `CK({alarm_word[1], config_warning_code}, {x != '0, x})
    endtask
    task automatic t_cfg;
        cfg(4'hA, TY, US, '0, '0, 5'h01);
        cfg('0, 16'h1031, US, '0, '0, 5'h04);
        cfg('0, TY, 16'h0011, '0, '0, 5'h06);
        cfg('0, 16'h1133, US, '0, '0, 5'h0A);
        cfg('0, TY, US, 4'h2, '0, 5'h0F);
        cfg('0, TY, US, 4'hF, '0, 5'h12);
        cfg('0, TY, US, '0, 5'h10, 5'h13);
        cfg('0, TY, US, '0, 5'h08, 5'h14);
        cfg('0, TY, 16'h0001, '0, '0, 5'h15);
        cfg('0, TY, US, '0, 5'h04, 5'h16);
        cfg('0, TY, US, '0, 5'h02, 5'h17);
        cfg('0, TY, US, '0, 5'h01, 5'h18);
        cfg('0, TY, US, '0, '0, 5'h00);
    endtask
    task automatic t_link;
        link_alarm_enable <= 1'b1;
        link_enabling_mode <= 4'h2;
        apb(1'b1, `RA_CMD, 32'h00000101);
        wt(45);
        `CK(alarm_word[3:2], 2'h1)
        wt(40);
        `CK(alarm_word[3:2], 2'h3)
        link_enabling_mode <= 4'h6;
        wt(3);
        `CK(alarm_word[3:2], 2'h2)
        apb(1'b1, `RA_LINK, 32'h00020001);
        apb(1'b1, `RA_CMD, 32'h00000100);
        wt(60);
        `CK({alarm_word[3:2], valve_enable_command}, 3'h0)
    endtask
    task automatic results;
        $display("checked %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // free-running clock
    initial forever #5 pclk = ~pclk;
    // watchdog, the run needs under 2000 cycles
    initial begin
        #100us;
        err_total++;
        results;
    end
    initial begin
        wt(6);
        presetn <= 1'b1;
        t_misc;
        t_cmd;
        t_stat;
        t_alarm;
        t_cfg;
        t_link;
        results;
    end
endmodule // vdca_tb
